// ==== lp3b_pkg.sv ====
// Purpose: Shared types and constants of the LPDDR3 power and bank FSM.
// Assumes: A 20 MHz fabric clock that oversamples the memory clock pin.
// Notes: Timing figures are plain defaults in nanoseconds.
package lp3b_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int T_RCD_NS = 18;
  localparam int T_RP_NS = 21;
  localparam int T_RFCPB_NS = 90;
  localparam int T_RFCAB_NS = 130;
  localparam int T_MRR_NS = 100;
  localparam int T_MRW_NS = 100;
  localparam int T_INIT5_NS = 10000;
  localparam logic [15:0] RCD_CYC = 16'((T_RCD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] RP_CYC = 16'((T_RP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] RFCPB_CYC =
    16'((T_RFCPB_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] RFCAB_CYC =
    16'((T_RFCAB_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] MRR_CYC = 16'((T_MRR_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] MRW_CYC = 16'((T_MRW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] INIT5_CYC =
    16'((T_INIT5_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] ONE_CYC = 16'h0001;
  // Burst length 8 on a double data rate bus is four memory clocks.
  localparam logic [2:0] BURST_CK = 3'h4;
  localparam int NUM_BANKS = 8;

  // ----------------------------------------------------------------
  // Command encodings on rising-edge CA, bit 0 is CA0
  // ----------------------------------------------------------------
  localparam logic [3:0] ENC_MRW = 4'h0;
  localparam logic [3:0] ENC_MRR = 4'h8;
  localparam logic [3:0] ENC_REFPB = 4'h4;
  localparam logic [3:0] ENC_REFAB = 4'hC;
  localparam logic [3:0] ENC_PRE = 4'hB;
  localparam logic [1:0] ENC_ACT = 2'h2;
  localparam logic [2:0] ENC_WR = 3'h1;
  localparam logic [2:0] ENC_RD = 3'h5;
  localparam logic [2:0] ENC_NOP = 3'h7;
  localparam logic [2:0] ENC_SREF = 3'h4;
  localparam logic [2:0] ENC_DPD = 3'h3;
  localparam logic [7:0] RESET_MA = 8'h3F;
  localparam int CA_AP = 0;
  localparam int CA_AB = 4;
  localparam int CA_MA = 4;
  localparam int CA_BA = 7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DEV_POWER_ON, DEV_RESETTING, DEV_RST_MRR, DEV_NORMAL, DEV_ACT_PD,
    DEV_IDLE_PD, DEV_RST_PD, DEV_SREF, DEV_DPD
  } lp3b_dev_e;

  typedef enum logic [3:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READING, BK_WRITING, BK_RD_AP,
    BK_WR_AP, BK_PRECHARGING, BK_REF_PB, BK_REF_AB, BK_MRR, BK_MRW
  } lp3b_bank_e;

  typedef enum logic [2:0] {
    OP_ACT, OP_RD, OP_WR, OP_PRE, OP_REF, OP_MRR, OP_MRW, OP_RST
  } lp3b_op_e;

  typedef lp3b_bank_e [NUM_BANKS-1:0] lp3b_bank_vec_t;

  typedef struct packed {
    logic valid;
    lp3b_op_e op;
    logic ap;
    logic all;
    logic [2:0] bank;
  } lp3b_cmd_s;

  typedef struct packed {
    logic ck;
    logic cke;
    logic cs_n;
    logic odt;
    logic [9:0] ca;
  } lp3b_pins_s;

  typedef struct packed {
    lp3b_bank_e st;
    lp3b_bank_e ret;
    logic [15:0] cnt;
    logic [2:0] burst;
  } lp3b_bank_s;

  typedef struct packed {
    lp3b_pins_s s1;
    lp3b_pins_s s2;
    logic ck_prev;
    logic cke_prev;
    logic pend;
    logic [9:0] ca_r;
    lp3b_dev_e dev;
    logic [15:0] cnt;
    logic [15:0] init_cnt;
    logic init_run;
    logic init_done;
    lp3b_cmd_s cmd;
    logic accept;
    logic reject;
    logic dq_term;
  } lp3b_top_s;

endpackage

// ==== lp3b_bank_fsm.sv ====
// Purpose: State and timing window of one DRAM bank.
// Assumes: Commands arrive already checked for legality by the top.
// Notes: Timed windows count fabric cycles, bursts count memory clocks.
`timescale 1ns/1ps
module lp3b_bank_fsm
  import lp3b_pkg::*;
#(
  parameter logic [2:0] BANK_ID = 3'h0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Command and memory clock edge
  input wire logic ck_rise_in,
  input wire lp3b_cmd_s cmd_in,
  // Bank status
  output lp3b_bank_e state_out,
  output logic idle_out,
  output logic open_out,
  output logic pre_ok_out,
  output logic rw_ok_out,
  output logic locked_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  lp3b_bank_s q;
  lp3b_bank_s d;
  logic hit;
  logic done;

  always_comb begin
    d = q;
    hit = cmd_in.valid && (cmd_in.all || cmd_in.bank == BANK_ID);
    done = q.cnt == 16'h0000;
    if (!done) begin
      d.cnt = q.cnt - ONE_CYC;
    end
    if (ck_rise_in && q.burst != 3'h0) begin
      d.burst = q.burst - 3'h1;
    end
    case (q.st)
      BK_IDLE: begin
        if (hit && cmd_in.op == OP_ACT) begin
          d.st = BK_ACTIVATING;
          d.cnt = RCD_CYC - ONE_CYC;
        end else if (hit && cmd_in.op == OP_REF) begin
          d.st = cmd_in.all ? BK_REF_AB : BK_REF_PB;
          d.cnt = (cmd_in.all ? RFCAB_CYC : RFCPB_CYC) - ONE_CYC;
        end else if (hit && cmd_in.op == OP_MRW) begin
          d.st = BK_MRW;
          d.cnt = MRW_CYC - ONE_CYC;
        end else if (hit && cmd_in.op == OP_MRR) begin
          d.st = BK_MRR;
          d.ret = BK_IDLE;
          d.cnt = MRR_CYC - ONE_CYC;
        end else if (hit && cmd_in.op == OP_PRE) begin
          d.st = BK_PRECHARGING;
          d.cnt = RP_CYC - ONE_CYC;
        end
      end
      BK_ACTIVE, BK_READING, BK_WRITING: begin
        if (q.st != BK_ACTIVE && q.burst == 3'h0) begin
          d.st = BK_ACTIVE;
        end
        if (hit && (cmd_in.op == OP_RD || cmd_in.op == OP_WR)) begin
          // Auto precharge may be chosen freshly on every column command.
          if (cmd_in.op == OP_RD) begin
            d.st = cmd_in.ap ? BK_RD_AP : BK_READING;
          end else begin
            d.st = cmd_in.ap ? BK_WR_AP : BK_WRITING;
          end
          d.burst = BURST_CK;
        end else if (hit && cmd_in.op == OP_PRE) begin
          d.st = BK_PRECHARGING;
          d.cnt = RP_CYC - ONE_CYC;
        end else if (hit && cmd_in.op == OP_MRR && q.st == BK_ACTIVE) begin
          d.st = BK_MRR;
          d.ret = BK_ACTIVE;
          d.cnt = MRR_CYC - ONE_CYC;
        end
      end
      BK_RD_AP, BK_WR_AP: begin
        if (q.burst == 3'h0) begin
          d.st = BK_PRECHARGING;
          d.cnt = RP_CYC - ONE_CYC;
        end
      end
      BK_ACTIVATING: begin
        if (done) begin
          d.st = BK_ACTIVE;
        end
      end
      BK_MRR: begin
        if (done) begin
          d.st = q.ret;
        end
      end
      BK_PRECHARGING, BK_REF_PB, BK_REF_AB, BK_MRW: begin
        if (done) begin
          d.st = BK_IDLE;
        end
      end
      default: begin
        d.st = BK_IDLE;
      end
    endcase
    if (hit && cmd_in.op == OP_RST) begin
      d.st = BK_IDLE;
      d.cnt = 16'h0000;
      d.burst = 3'h0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q <= '{st: BK_IDLE, ret: BK_IDLE, cnt: 16'h0000, burst: 3'h0};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  assign state_out = q.st;
  assign idle_out = q.st == BK_IDLE;
  assign rw_ok_out = q.st inside {BK_ACTIVE, BK_READING, BK_WRITING};
  assign pre_ok_out = rw_ok_out || idle_out;
  assign open_out = q.st inside {BK_ACTIVATING, BK_ACTIVE, BK_READING,
    BK_WRITING, BK_RD_AP, BK_WR_AP};
  assign locked_out = q.st inside {BK_REF_PB, BK_REF_AB, BK_MRR, BK_MRW};

endmodule

// ==== lp3b_power_bank_fsm.sv ====
// Purpose: Power state and bank state sequencing of an LPDDR3 die.
// Assumes: Memory clock pin is slow next to the fabric clock.
// Notes: Commands are registered at the falling memory clock edge.
`timescale 1ns/1ps
module lp3b_power_bank_fsm
  import lp3b_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Memory command pins
  input wire logic ck_in,
  input wire logic cke_in,
  input wire logic cs_n_in,
  input wire logic [9:0] ca_in,
  // Configuration
  input wire logic odt_enable_in,
  // Status
  output lp3b_dev_e dev_state_out,
  output lp3b_bank_vec_t bank_state_out,
  output logic init_done_out,
  output logic cmd_accept_out,
  output logic cmd_reject_out,
  // Data pin condition
  output logic dq_hiz_out,
  output logic dq_term_out
);

  // ----------------------------------------------------------------
  // State and bank status
  // ----------------------------------------------------------------
  lp3b_top_s q;
  lp3b_top_s d;
  lp3b_pins_s pins;
  lp3b_bank_vec_t bank_st;
  logic [NUM_BANKS-1:0] idle_v;
  logic [NUM_BANKS-1:0] open_v;
  logic [NUM_BANKS-1:0] pre_ok_v;
  logic [NUM_BANKS-1:0] rw_ok_v;
  logic [NUM_BANKS-1:0] locked_v;
  logic ck_rise;
  logic ck_fall;
  logic all_idle;
  logic normal;
  logic ok;
  logic nop;
  logic to_banks;
  logic [2:0] ba;
  logic [7:0] ma;

  assign pins.ck = ck_in;
  assign pins.cke = cke_in;
  assign pins.cs_n = cs_n_in;
  assign pins.odt = odt_enable_in;
  assign pins.ca = ca_in;

  // ----------------------------------------------------------------
  // Banks
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    lp3b_bank_fsm #(
      .BANK_ID(3'(g))
    ) u_bank (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .ck_rise_in(ck_rise),
      .cmd_in(q.cmd),
      .state_out(bank_st[g]),
      .idle_out(idle_v[g]),
      .open_out(open_v[g]),
      .pre_ok_out(pre_ok_v[g]),
      .rw_ok_out(rw_ok_v[g]),
      .locked_out(locked_v[g])
    );
  end

  // ----------------------------------------------------------------
  // Power and command sequencing
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    // Pins are asynchronous to the fabric clock, so two stages first.
    d.s1 = pins;
    d.s2 = q.s1;
    d.ck_prev = q.s2.ck;
    d.cmd = '0;
    d.accept = 1'b0;
    d.reject = 1'b0;
    ck_rise = q.s2.ck && !q.ck_prev;
    ck_fall = !q.s2.ck && q.ck_prev;
    all_idle = &idle_v;
    normal = q.dev == DEV_NORMAL && !(|locked_v);
    ok = 1'b0;
    nop = 1'b0;
    to_banks = 1'b1;
    ba = q.ca_r[CA_BA +: 3];
    ma = {q.s2.ca[1:0], q.ca_r[CA_MA +: 6]};

    // --------------------------------------------------------------
    // Initialization wait and resetting mode read timer
    // --------------------------------------------------------------
    // The wait runs on in every power state, so a long resetting power
    // down can end straight in idle.
    if (q.init_run) begin
      if (q.init_cnt != 16'h0000) begin
        d.init_cnt = q.init_cnt - ONE_CYC;
      end else begin
        d.init_run = 1'b0;
        d.init_done = 1'b1;
      end
    end
    if (q.dev == DEV_RESETTING && q.init_done) begin
      d.dev = DEV_NORMAL;
    end
    if (q.dev == DEV_RST_MRR) begin
      if (q.cnt != 16'h0000) begin
        d.cnt = q.cnt - ONE_CYC;
      end else begin
        d.dev = DEV_RESETTING;
      end
    end

    // --------------------------------------------------------------
    // Clock enable judgement at each rising memory clock
    // --------------------------------------------------------------
    if (ck_rise) begin
      d.cke_prev = q.s2.cke;
      d.pend = 1'b0;
      case ({q.cke_prev, q.s2.cke})
        2'b01: begin
          if (q.s2.cs_n) begin
            case (q.dev)
              DEV_ACT_PD, DEV_IDLE_PD, DEV_SREF: begin
                d.dev = DEV_NORMAL;
              end
              DEV_RST_PD: begin
                d.dev = q.init_done ? DEV_NORMAL :
                  DEV_RESETTING;
              end
              DEV_DPD: begin
                d.dev = DEV_POWER_ON;
                d.init_done = 1'b0;
              end
              default: begin
                d.dev = q.dev;
              end
            endcase
          end
        end
        2'b10: begin
          if (q.s2.cs_n && q.dev == DEV_NORMAL) begin
            d.dev = (|open_v) ? DEV_ACT_PD : DEV_IDLE_PD;
          end else if (q.s2.cs_n && q.dev == DEV_RESETTING) begin
            d.dev = DEV_RST_PD;
          end else if (!q.s2.cs_n && normal && all_idle) begin
            if (q.s2.ca[2:0] == ENC_SREF) begin
              d.dev = DEV_SREF;
            end else if (q.s2.ca[2:0] == ENC_DPD) begin
              d.dev = DEV_DPD;
            end
          end
        end
        2'b11: begin
          if (!q.s2.cs_n) begin
            // Only the rising half is kept; the falling half comes later.
            d.pend = 1'b1;
            d.ca_r = q.s2.ca;
          end
        end
        default: begin
          // Both samples low keep every low-power state.
          d.dev = q.dev;
        end
      endcase
    end

    // --------------------------------------------------------------
    // Command decode at the falling memory clock
    // --------------------------------------------------------------
    // The falling half of CA is read straight from the synchroniser, as
    // it stands beside the falling clock that it belongs to.
    if (ck_fall && q.pend) begin
      d.pend = 1'b0;
      d.cmd.bank = ba;
      d.cmd.ap = q.s2.ca[CA_AP];
      if (q.ca_r[3:0] == ENC_MRW) begin
        d.cmd.all = 1'b1;
        if (ma == RESET_MA) begin
          d.cmd.op = OP_RST;
          ok = q.dev == DEV_POWER_ON || (normal && all_idle);
          if (ok) begin
            d.dev = DEV_RESETTING;
            d.init_cnt = INIT5_CYC - ONE_CYC;
            d.init_run = 1'b1;
            d.init_done = 1'b0;
          end
        end else begin
          d.cmd.op = OP_MRW;
          ok = normal && all_idle;
        end
      end else if (q.ca_r[3:0] == ENC_MRR) begin
        d.cmd.op = OP_MRR;
        d.cmd.all = 1'b1;
        if (q.dev == DEV_RESETTING) begin
          ok = 1'b1;
          to_banks = 1'b0;
          d.dev = DEV_RST_MRR;
          d.cnt = MRR_CYC - ONE_CYC;
        end else begin
          ok = normal;
        end
      end else if (q.ca_r[3:0] == ENC_REFPB) begin
        d.cmd.op = OP_REF;
        ok = normal && idle_v[ba];
      end else if (q.ca_r[3:0] == ENC_REFAB) begin
        d.cmd.op = OP_REF;
        d.cmd.all = 1'b1;
        ok = normal && all_idle;
      end else if (q.ca_r[3:0] == ENC_PRE) begin
        d.cmd.op = OP_PRE;
        d.cmd.all = q.ca_r[CA_AB];
        ok = normal &&
          (q.ca_r[CA_AB] ? &pre_ok_v : pre_ok_v[ba]);
      end else if (q.ca_r[1:0] == ENC_ACT) begin
        d.cmd.op = OP_ACT;
        ok = normal && idle_v[ba];
      end else if (q.ca_r[2:0] == ENC_RD || q.ca_r[2:0] == ENC_WR) begin
        d.cmd.op = q.ca_r[2:0] == ENC_RD ? OP_RD : OP_WR;
        // A bank in an auto-precharge or timed window is not column-ready.
        ok = normal && rw_ok_v[ba];
      end else if (q.ca_r[2:0] == ENC_NOP) begin
        nop = 1'b1;
      end
      d.cmd.valid = ok && to_banks;
      d.accept = ok;
      d.reject = !ok && !nop;
    end

    // --------------------------------------------------------------
    // Data pin condition
    // --------------------------------------------------------------
    // Termination replaces the floating outputs only in self refresh.
    d.dq_term = d.dev == DEV_SREF && q.s2.odt;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      // Each field is named so that its reset level is plain to read.
      q.s1 <= '0;
      q.s2 <= '0;
      q.ck_prev <= 1'b0;
      q.cke_prev <= 1'b0;
      q.pend <= 1'b0;
      q.ca_r <= 10'h000;
      q.dev <= DEV_POWER_ON;
      q.cnt <= 16'h0000;
      q.init_cnt <= 16'h0000;
      q.init_run <= 1'b0;
      q.init_done <= 1'b0;
      q.cmd <= '0;
      q.accept <= 1'b0;
      q.reject <= 1'b0;
      q.dq_term <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dev_state_out = q.dev;
  assign bank_state_out = bank_st;
  assign init_done_out = q.init_done;
  assign cmd_accept_out = q.accept;
  assign cmd_reject_out = q.reject;
  assign dq_term_out = q.dq_term;
  assign dq_hiz_out = !q.dq_term;

endmodule

// ==== lp3b_ctrl_model.sv ====
// Purpose: Controller model that drives the command pins of the die.
// Assumes: A free running 400 ns pin clock, phase unrelated to clk_in.
// Notes: A deselected CA bus shows the inverse of its last value.
`timescale 1ns/1ps
module lp3b_ctrl_model (
  // Command pins
  output logic ck_out,
  output logic cke_out,
  output logic cs_n_out,
  output logic [9:0] ca_out
);
  initial begin
    ck_out = 1'b0;
    cke_out = 1'b0;
    cs_n_out = 1'b1;
    ca_out = 10'h000;
    #13;
    forever #200 ck_out = ~ck_out;
  end

  // ----------------------------------------------------------------
  // One command period, then one deselected period
  // ----------------------------------------------------------------
  // Entered just after a pin clock fall; every pin moves midway between
  // edges, so both halves of CA are stable where the die samples them.
  task automatic issue(input logic cs, input logic ke,
      input logic [9:0] car, input logic [9:0] caf);
    #100;
    cke_out = ke;
    cs_n_out = cs;
    ca_out = cs ? ~ca_out : car;
    @(posedge ck_out);
    #100;
    ca_out = cs ? ~ca_out : caf;
    @(negedge ck_out);
    #100;
    cs_n_out = 1'b1;
    ca_out = ~ca_out;
    @(posedge ck_out);
    #100;
    ca_out = ~ca_out;
    @(negedge ck_out);
  endtask
endmodule

// ==== lp3b_power_bank_fsm_checker.sv ====
// Purpose: Timing checks on the status ports of the power and bank FSM.
// Assumes: Timed bank states last the cycle counts of the package.
// Notes: Burst lengths follow the pin clock and are left to the bench.
`timescale 1ns/1ps
module lp3b_power_bank_fsm_checker
  import lp3b_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Status
  input wire lp3b_dev_e dev_state_out,
  input wire lp3b_bank_vec_t bank_state_out,
  input wire logic init_done_out,
  input wire logic cmd_accept_out,
  input wire logic cmd_reject_out,
  input wire logic dq_hiz_out,
  input wire logic dq_term_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  property p_excl;
    !(cmd_accept_out && cmd_reject_out);
  endproperty
  a_excl: assert property (p_excl)
    else $error("accept with reject");
  property p_pulse;
    cmd_accept_out |=> !cmd_accept_out;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("accept too long");
  property p_rej;
    cmd_reject_out |=> $stable(dev_state_out);
  endproperty
  a_rej: assert property (p_rej)
    else $error("refused moved state");
  property p_term;
    dq_hiz_out != dq_term_out &&
      (!dq_term_out || dev_state_out == DEV_SREF);
  endproperty
  a_term: assert property (p_term)
    else $error("data pin mode");
  property p_rstpd;
    $past(dev_state_out) == DEV_RST_PD && dev_state_out == DEV_NORMAL
      |-> $past(init_done_out);
  endproperty
  a_rstpd: assert property (p_rstpd) else $error("early idle");
  property p_dpd;
    $past(dev_state_out) == DEV_DPD && dev_state_out != DEV_DPD
      |-> dev_state_out == DEV_POWER_ON;
  endproperty
  a_dpd: assert property (p_dpd) else $error("deep exit");

  for (genvar gi = 0; gi < NUM_BANKS; gi++) begin : g_bk
    property p_rcd;
      $rose(bank_state_out[gi] == BK_ACTIVATING)
        |=> bank_state_out[gi] == BK_ACTIVE;
    endproperty
    a_rcd: assert property (p_rcd)
      else $error("activate window");
    property p_rp;
      $rose(bank_state_out[gi] == BK_PRECHARGING)
        |=> bank_state_out[gi] == BK_IDLE;
    endproperty
    a_rp: assert property (p_rp)
      else $error("precharge window");
    property p_rfpb;
      $rose(bank_state_out[gi] == BK_REF_PB)
        |=> bank_state_out[gi] == BK_REF_PB ##1 bank_state_out[gi] == BK_IDLE;
    endproperty
    a_rfpb: assert property (p_rfpb)
      else $error("bank refresh");
    property p_rfab;
      $rose(bank_state_out[gi] == BK_REF_AB)
        |=> bank_state_out[gi] == BK_REF_AB [*2] ##1
        bank_state_out[gi] == BK_IDLE;
    endproperty
    a_rfab: assert property (p_rfab)
      else $error("all refresh");
    property p_mrw;
      $rose(bank_state_out[gi] == BK_MRW)
        |=> bank_state_out[gi] == BK_MRW ##1 bank_state_out[gi] == BK_IDLE;
    endproperty
    a_mrw: assert property (p_mrw) else $error("mode write");
    property p_mrr;
      $rose(bank_state_out[gi] == BK_MRR) |=> bank_state_out[gi] == BK_MRR
        ##1 bank_state_out[gi] == $past(bank_state_out[gi], 3);
    endproperty
    a_mrr: assert property (p_mrr) else $error("mode read");
  end
endmodule

bind lp3b_power_bank_fsm lp3b_power_bank_fsm_checker u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .dev_state_out(dev_state_out),
  .bank_state_out(bank_state_out), .init_done_out(init_done_out),
  .cmd_accept_out(cmd_accept_out), .cmd_reject_out(cmd_reject_out),
  .dq_hiz_out(dq_hiz_out), .dq_term_out(dq_term_out)
);

// ==== lp3b_power_bank_fsm_tb.sv ====
// Purpose: Self-checking bench of the power and bank FSM.
// Assumes: The controller model owns the pin clock and command pins.
// Notes: Each command is followed by a deselected period before checks.
`timescale 1ns/1ps
module lp3b_power_bank_fsm_tb
  import lp3b_pkg::*;
;
  typedef struct packed {
    logic [9:0] car;
    logic [9:0] caf;
    logic acc;
    logic [2:0] bank;
    lp3b_bank_e st;
  } lp3b_row_s;

  logic clk_in, reset_in, odt, ck, cke, cs_n, init_done, acc, rej, hiz, term;
  logic [9:0] ca;
  lp3b_dev_e dev_state_out;
  lp3b_bank_vec_t bank_state_out;
  int fails = 0, samples_checked = 0, acc_n = 0, rej_n = 0, a0, r0;
  // Illegal commands sit between legal ones so refusals are seen to
  // leave the states that the next rows depend on untouched.
  lp3b_row_s rows [16] = '{
    '{10'h102, 10'h000, 1'b1, 3'h2, BK_ACTIVE},
    '{10'h102, 10'h000, 1'b0, 3'h2, BK_ACTIVE},
    '{10'h185, 10'h000, 1'b0, 3'h3, BK_IDLE},
    '{10'h18B, 10'h000, 1'b1, 3'h3, BK_IDLE},
    '{10'h184, 10'h000, 1'b1, 3'h3, BK_IDLE},
    '{10'h104, 10'h000, 1'b0, 3'h2, BK_ACTIVE},
    '{10'h00C, 10'h000, 1'b0, 3'h2, BK_ACTIVE},
    '{10'h010, 10'h000, 1'b0, 3'h2, BK_ACTIVE},
    '{10'h018, 10'h000, 1'b1, 3'h2, BK_ACTIVE},
    '{10'h003, 10'h000, 1'b0, 3'h2, BK_ACTIVE},
    '{10'h01B, 10'h000, 1'b1, 3'h2, BK_IDLE},
    '{10'h00C, 10'h000, 1'b1, 3'h2, BK_IDLE},
    '{10'h010, 10'h000, 1'b1, 3'h0, BK_IDLE},
    '{10'h282, 10'h000, 1'b1, 3'h5, BK_ACTIVE},
    '{10'h281, 10'h000, 1'b1, 3'h5, BK_WRITING},
    '{10'h105, 10'h000, 1'b0, 3'h2, BK_IDLE}
  };

  lp3b_ctrl_model m (.ck_out(ck), .cke_out(cke), .cs_n_out(cs_n),
    .ca_out(ca));
  lp3b_power_bank_fsm uut (.clk_in(clk_in), .reset_in(reset_in),
    .ck_in(ck), .cke_in(cke), .cs_n_in(cs_n), .ca_in(ca),
    .odt_enable_in(odt), .dev_state_out(dev_state_out),
    .bank_state_out(bank_state_out), .init_done_out(init_done),
    .cmd_accept_out(acc), .cmd_reject_out(rej), .dq_hiz_out(hiz),
    .dq_term_out(term));

  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    acc_n += acc;
    rej_n += rej;
  end

  // A stalled pin clock would hang the model, so the run is bounded.
  initial begin
    repeat (4000) @(posedge clk_in);
    fails++;
    $display("BAD %0t timeout", $time);
    complete_run();
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string what);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  task automatic cmd(input logic [9:0] car, input logic [9:0] caf,
      input logic ex);
    a0 = acc_n;
    r0 = rej_n;
    m.issue(1'b0, 1'b1, car, caf);
    chk(((acc_n - a0) == 1) === ex && ((rej_n - r0) == 1) !== ex, "answer");
  endtask
  task automatic pw(input logic cs, input logic ke, input logic [9:0] car,
      input lp3b_dev_e e);
    m.issue(cs, ke, car, 10'h000);
    chk(dev_state_out === e, "power state");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    reset_in = 1'b1;
    odt = 1'b0;
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    reset_in = 1'b0;
    chk(hiz === 1'b1 && term === 1'b0, "reset pins");
    chk(init_done === 1'b0, "reset init");
    @(negedge ck);
    pw(1'b1, 1'b1, 10'h000, DEV_POWER_ON);
    pw(1'b1, 1'b1, 10'h000, DEV_POWER_ON);
    pw(1'b0, 1'b1, 10'h3F0, DEV_RESETTING);
    pw(1'b1, 1'b0, 10'h000, DEV_RST_PD);
    pw(1'b1, 1'b1, 10'h000, DEV_RESETTING);
    cmd(10'h018, 10'h000, 1'b1);
    repeat (14) pw(1'b1, 1'b0, 10'h000, DEV_RST_PD);
    pw(1'b1, 1'b1, 10'h000, DEV_NORMAL);
    chk(init_done === 1'b1, "init wait");
    for (int i = 0; i < 16; i++) begin
      cmd(rows[i].car, rows[i].caf, rows[i].acc);
      chk(bank_state_out[rows[i].bank] === rows[i].st, "bank");
    end
    cmd(10'h285, 10'h000, 1'b1);
    chk(bank_state_out[5] === BK_READING, "read burst");
    repeat (2) m.issue(1'b1, 1'b1, 10'h000, 10'h000);
    chk(bank_state_out[5] === BK_ACTIVE, "burst end");
    cmd(10'h281, 10'h001, 1'b1);
    chk(bank_state_out[5] === BK_WR_AP, "auto precharge");
    repeat (2) m.issue(1'b1, 1'b1, 10'h000, 10'h000);
    chk(bank_state_out[5] === BK_IDLE, "auto idle");
    cmd(10'h082, 10'h000, 1'b1);
    pw(1'b1, 1'b0, 10'h000, DEV_ACT_PD);
    pw(1'b0, 1'b0, 10'h3FF, DEV_ACT_PD);
    pw(1'b1, 1'b1, 10'h000, DEV_NORMAL);
    cmd(10'h01B, 10'h000, 1'b1);
    pw(1'b1, 1'b0, 10'h000, DEV_IDLE_PD);
    pw(1'b1, 1'b1, 10'h000, DEV_NORMAL);
    @(negedge clk_in);
    odt = 1'b1;
    pw(1'b0, 1'b0, 10'h004, DEV_SREF);
    chk(term === 1'b1 && hiz === 1'b0, "termination");
    pw(1'b1, 1'b1, 10'h000, DEV_NORMAL);
    chk(hiz === 1'b1, "released");
    pw(1'b0, 1'b0, 10'h003, DEV_DPD);
    pw(1'b0, 1'b0, 10'h3FF, DEV_DPD);
    pw(1'b1, 1'b1, 10'h000, DEV_POWER_ON);
    complete_run();
  end
endmodule
